// *** spi_core_defs.svh ***
// serial port core constants: field widths, reset values, timing
// assumes inclusion by bare name from design files
`ifndef SPI_CORE_DEFS_SVH
`define SPI_CORE_DEFS_SVH

`define WORD_BITS          8
`define DIV_BITS           16
`define THR_BITS           3
`define DIV_RESET          16'h0000
`define THR_RESET          3'h1
`define INT_CLK_MHZ        160
`define MASTER_MAX_MBPS    80
`define SLAVE_MAX_MBPS     24
`define EXT_MIN_PHASE_CLKS 3
`define SYNC_STAGES        3
`define FIFO_DEPTH         8
`define ROOM_DEPTH         2

`endif

// *** spi_core_pkg.sv ***
// serial port core types
// assumes constants come from spi_core_defs.svh
package spi_core_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LEAD,
        ST_SHIFT,
        ST_TRAIL
    } xfer_state_type;

    typedef enum logic {
        FMT_FOUR_WIRE,
        FMT_SYNC_PORT
    } frame_format_type;
endpackage

// *** spi_word_buffer.sv ***
// two-entry valid/ready buffer for one data word
// assumes single clock, asynchronous active-low reset
`timescale 1ns/1ps
`include "spi_core_defs.svh"
module spi_word_buffer #(
    parameter int WIDTH = `WORD_BITS
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    initial begin
        if (WIDTH < 1) begin
            $error("width must be positive");
        end
    end

    logic [WIDTH-1:0] mem_ff [2];
    logic             wptr_ff;
    logic             rptr_ff;
    logic [1:0]       cnt_ff;
    wire              push = in_valid_i && in_ready_o;
    wire              pop  = out_valid_o && out_ready_i;

    assign in_ready_o  = (cnt_ff != 2'h2);
    assign out_valid_o = (cnt_ff != 2'h0);
    assign out_data_o  = mem_ff[rptr_ff];

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wptr_ff <= 1'b0;
            rptr_ff <= 1'b0;
            cnt_ff  <= 2'h0;
        end else begin
            if (push) begin
                wptr_ff <= ~wptr_ff;
            end
            if (pop) begin
                rptr_ff <= ~rptr_ff;
            end
            if (push && !pop) begin
                cnt_ff <= cnt_ff + 2'h1;
            end else if (pop && !push) begin
                cnt_ff <= cnt_ff - 2'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_ff[wptr_ff] <= in_data_i;
        end
    end
endmodule

// *** spi_master_slave_core.sv ***
// serial port controller, master or slave, fifo-backed word stream
// assumes clk_i is the internal port clock; pins enter asynchronously
`timescale 1ns/1ps
`include "spi_core_defs.svh"
module spi_master_slave_core #(
    parameter int W     = `WORD_BITS,
    parameter int DEPTH = `FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    // configuration
    input  wire logic                   enable_i,
    input  wire logic                   master_i,
    input  wire logic                   full_duplex_i,
    input  wire logic                   lsb_first_i,
    input  wire logic                   sync_format_i,
    input  wire logic                   ext_clock_i,
    input  wire logic                   clock_idle_polarity_i,
    input  wire logic                   clock_phase_select_i,
    input  wire logic [`DIV_BITS-1:0]   serial_clock_divider_i,
    input  wire logic [`THR_BITS-1:0]   tx_threshold_i,
    input  wire logic [`THR_BITS-1:0]   rx_threshold_i,
    input  wire logic [3:0]             int_enable_i,
    // data register access
    input  wire logic                   data_wr_i,
    input  wire logic [W-1:0]           data_wdata_i,
    output logic                        data_wready_o,
    input  wire logic                   data_rd_i,
    output logic                        data_rvalid_o,
    output logic [W-1:0]                data_rdata_o,
    input  wire logic                   status_clear_i,
    // status, interrupt, dma
    output logic [3:0]                  int_status_o,
    output logic                        irq_o,
    output logic                        tx_dma_req_o,
    output logic                        rx_dma_req_o,
    output logic                        busy_o,
    // serial pins
    output logic                        serial_clock_o,
    output logic                        serial_clock_oe_o,
    output logic                        serial_data_o,
    input  wire logic                   serial_data_i,
    input  wire logic                   external_serial_clock_in_i,
    input  wire logic                   chip_select_low_i,
    output logic                        chip_select_low_o
);
    initial begin
        if (W < 2 || W > 32 || DEPTH < 2 || DEPTH > 64) begin
            $error("unsupported width or depth");
        end
    end

    localparam int AW = $clog2(DEPTH);

    // pin synchronisers, three stages
    logic [2:0] sck_sync_ff;
    logic [2:0] cs_sync_ff;
    logic [2:0] din_sync_ff;
    logic       sck_ff;
    logic       cs_n_ff;

    // fifos
    logic [W-1:0]  tx_mem_ff [DEPTH];
    logic [W-1:0]  rx_mem_ff [DEPTH];
    logic [AW:0]   tx_wp_ff;
    logic [AW:0]   tx_rp_ff;
    logic [AW:0]   rx_wp_ff;
    logic [AW:0]   rx_rp_ff;
    logic [W-1:0]  last_tx_ff;

    // engine
    spi_core_pkg::xfer_state_type state_ff;
    logic [`DIV_BITS-1:0] div_cnt_ff;
    logic                 sclk_ff;
    logic [W-1:0]         tx_sh_ff;
    logic [W-1:0]         rx_sh_ff;
    logic [5:0]           bit_cnt_ff;
    logic                 rx_phase_ff;
    logic                 cs_out_ff;
    logic                 dout_ff;
    logic [3:0]           int_status_ff;
    logic                 sck_prev_ff;

    wire [AW:0] tx_level = tx_wp_ff - tx_rp_ff;
    wire [AW:0] rx_level = rx_wp_ff - rx_rp_ff;
    wire        tx_empty = (tx_level == '0);
    wire        tx_full  = (tx_level == (AW+1)'(DEPTH));
    wire        rx_empty = (rx_level == '0);
    wire        rx_full  = (rx_level == (AW+1)'(DEPTH));

    wire        use_sync  = sync_format_i && !master_i;
    wire        same_pp   = (clock_idle_polarity_i == clock_phase_select_i);
    wire        idle_lvl  = use_sync ? 1'b0 : clock_idle_polarity_i;
    wire        msb_first = use_sync || !lsb_first_i;
    wire        last_bit  = (bit_cnt_ff == 6'(W - 1));

    wire        sck_rise   = sck_ff && !sck_prev_ff;
    wire        sck_fall   = !sck_ff && sck_prev_ff;
    wire        samp_rise  = use_sync || same_pp;
    wire        ext_sample = samp_rise ? sck_rise : sck_fall;
    wire        ext_drive  = samp_rise ? sck_fall : sck_rise;

    wire        div_tick   = (div_cnt_ff >= serial_clock_divider_i);
    wire        int_next   = ~sclk_ff;
    wire        int_sample = div_tick && (samp_rise ? int_next : sclk_ff);
    wire        int_drive  = div_tick && !int_sample;
    wire        use_ext    = !master_i || ext_clock_i;
    wire        sample_ev  = use_ext ? ext_sample : int_sample;
    wire        drive_ev   = use_ext ? ext_drive : int_drive;

    wire        slave_sel  = !master_i && enable_i && !cs_n_ff;
    wire        tx_active  = full_duplex_i || (master_i ? !rx_phase_ff
                                                        : rx_phase_ff);
    wire        rx_active  = full_duplex_i || (master_i ? rx_phase_ff
                                                        : !rx_phase_ff);
    wire        word_done  = (state_ff == spi_core_pkg::ST_SHIFT)
                             && sample_ev && last_bit;
    wire        start_ok   = master_i ? (enable_i && (!tx_empty ||
                                         rx_phase_ff))
                                      : slave_sel;
    wire        load_tx    = (state_ff == spi_core_pkg::ST_IDLE) && start_ok
                             && tx_active;
    wire        rx_push    = word_done && rx_active && !rx_full;
    wire        rx_ovf     = word_done && rx_active && rx_full;
    wire        tx_under   = load_tx && tx_empty;
    wire        tx_pop     = load_tx && !tx_empty;
    wire        host_pop   = data_rd_i && !rx_empty;
    wire        host_push  = data_wr_i && !tx_full;
    wire [W-1:0] tx_word   = tx_empty ? last_tx_ff : tx_mem_ff[tx_rp_ff[AW-1:0]];
    wire [W-1:0] rx_word   = msb_first ? {rx_sh_ff[W-2:0], din_sync_ff[2]}
                                       : {din_sync_ff[2], rx_sh_ff[W-1:1]};
    wire        out_bit    = msb_first ? tx_sh_ff[W-1] : tx_sh_ff[0];
    wire [W-1:0] tx_shift  = msb_first ? {tx_sh_ff[W-2:0], 1'b0}
                                       : {1'b0, tx_sh_ff[W-1:1]};
    wire        tx_thr     = (tx_level <= (AW+1)'(tx_threshold_i));
    wire        rx_thr     = (rx_level >= (AW+1)'(rx_threshold_i)) && !rx_empty;
    wire [3:0]  int_events = {rx_thr, tx_thr, rx_ovf, tx_under};

    // stall-free delivery of received words
    logic buf_in_ready;
    spi_word_buffer #(
        .WIDTH(W)
    ) u_rx_buf (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .in_valid_i (host_pop),
        .in_ready_o (buf_in_ready),
        .in_data_i  (rx_mem_ff[rx_rp_ff[AW-1:0]]),
        .out_valid_o(data_rvalid_o),
        .out_ready_i(1'b1),
        .out_data_o (data_rdata_o)
    );

    // outputs
    assign data_wready_o     = !tx_full;
    assign serial_clock_o    = sclk_ff;
    assign serial_clock_oe_o = master_i && enable_i && !ext_clock_i;
    assign serial_data_o     = dout_ff;
    assign chip_select_low_o = cs_out_ff;
    assign int_status_o      = int_status_ff;
    assign irq_o             = |(int_status_ff & int_enable_i);
    assign tx_dma_req_o      = enable_i && tx_thr;
    assign rx_dma_req_o      = enable_i && rx_thr;
    assign busy_o            = (state_ff != spi_core_pkg::ST_IDLE);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sck_sync_ff <= 3'h0;
            cs_sync_ff  <= 3'h7;
            din_sync_ff <= 3'h0;
            sck_ff      <= 1'b0;
            cs_n_ff     <= 1'b1;
            sck_prev_ff <= 1'b0;
        end else begin
            sck_sync_ff <= {sck_sync_ff[1:0], external_serial_clock_in_i};
            cs_sync_ff  <= {cs_sync_ff[1:0], chip_select_low_i};
            din_sync_ff <= {din_sync_ff[1:0], serial_data_i};
            if (sck_sync_ff[1] == sck_sync_ff[2]) begin
                sck_ff <= sck_sync_ff[2];
            end
            if (cs_sync_ff[1] == cs_sync_ff[2]) begin
                cs_n_ff <= cs_sync_ff[2];
            end
            sck_prev_ff <= sck_ff;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_wp_ff <= '0;
            tx_rp_ff <= '0;
            rx_wp_ff <= '0;
            rx_rp_ff <= '0;
        end else begin
            tx_wp_ff <= tx_wp_ff + (AW+1)'(host_push);
            tx_rp_ff <= tx_rp_ff + (AW+1)'(tx_pop);
            rx_wp_ff <= rx_wp_ff + (AW+1)'(rx_push);
            rx_rp_ff <= rx_rp_ff + (AW+1)'(host_pop && buf_in_ready);
        end
    end

    always_ff @(posedge clk_i) begin
        if (host_push) begin
            tx_mem_ff[tx_wp_ff[AW-1:0]] <= data_wdata_i;
        end
        if (rx_push) begin
            rx_mem_ff[rx_wp_ff[AW-1:0]] <= rx_word;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            int_status_ff <= 4'h0;
        end else if (status_clear_i) begin
            int_status_ff <= int_events;
        end else begin
            int_status_ff <= int_status_ff | int_events;
        end
    end

    // transfer engine
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff    <= spi_core_pkg::ST_IDLE;
            div_cnt_ff  <= `DIV_RESET;
            sclk_ff     <= 1'b0;
            tx_sh_ff    <= '0;
            rx_sh_ff    <= '0;
            bit_cnt_ff  <= 6'h00;
            rx_phase_ff <= 1'b0;
            cs_out_ff   <= 1'b1;
            dout_ff     <= 1'b0;
            last_tx_ff  <= '0;
        end else begin
            div_cnt_ff <= div_tick ? `DIV_RESET : div_cnt_ff + 16'h0001;
            case (state_ff)
                spi_core_pkg::ST_IDLE: begin
                    sclk_ff <= idle_lvl;
                    bit_cnt_ff <= 6'h00;
                    if (!enable_i) begin
                        rx_phase_ff <= 1'b0;
                        cs_out_ff   <= 1'b1;
                    end else if (start_ok) begin
                        tx_sh_ff   <= tx_active ? tx_word : '0;
                        if (tx_pop) begin
                            last_tx_ff <= tx_word;
                        end
                        cs_out_ff  <= !master_i;
                        state_ff   <= spi_core_pkg::ST_LEAD;
                    end
                end
                spi_core_pkg::ST_LEAD: begin
                    dout_ff <= tx_active ? out_bit : 1'b0;
                    if (div_tick || use_ext) begin
                        state_ff <= spi_core_pkg::ST_SHIFT;
                    end
                end
                spi_core_pkg::ST_SHIFT: begin
                    if (!use_ext && div_tick) begin
                        sclk_ff <= int_next;
                    end
                    if (!master_i && !slave_sel) begin
                        state_ff <= spi_core_pkg::ST_IDLE;
                    end else if (sample_ev) begin
                        rx_sh_ff   <= rx_word;
                        tx_sh_ff   <= tx_shift;
                        bit_cnt_ff <= bit_cnt_ff + 6'h01;
                        if (last_bit) begin
                            state_ff <= spi_core_pkg::ST_TRAIL;
                        end
                    end else if (drive_ev && bit_cnt_ff != 6'h00) begin
                        dout_ff <= tx_active ? out_bit : 1'b0;
                    end
                end
                spi_core_pkg::ST_TRAIL: begin
                    if (!use_ext && div_tick) begin
                        sclk_ff <= idle_lvl;
                    end
                    if (div_tick || use_ext) begin
                        if (!full_duplex_i) begin
                            rx_phase_ff <= ~rx_phase_ff;
                        end
                        if (master_i && tx_empty && !(rx_phase_ff == 1'b0
                                && !full_duplex_i)) begin
                            cs_out_ff <= 1'b1;
                        end
                        state_ff <= spi_core_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_ff <= spi_core_pkg::ST_IDLE;
                end
            endcase
        end
    end
endmodule

// *** spi_core_chk_sva.sv ***
// checker: port-level timing relations of the serial core
// assumes one clock domain, bound to every core instance
`timescale 1ns/1ps
module spi_core_chk (
    // clock and reset
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    // configuration
    input wire logic        enable_i,
    input wire logic        master_i,
    input wire logic        ext_clock_i,
    input wire logic        clock_idle_polarity_i,
    input wire logic [15:0] serial_clock_divider_i,
    input wire logic [3:0]  int_enable_i,
    // access and status
    input wire logic        data_rd_i,
    input wire logic        data_rvalid_o,
    input wire logic        status_clear_i,
    input wire logic [3:0]  int_status_o,
    input wire logic        irq_o,
    input wire logic        busy_o,
    // serial pins
    input wire logic        serial_clock_o,
    input wire logic        serial_clock_oe_o,
    input wire logic        chip_select_low_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    logic        sclk_q_ff;
    logic [16:0] run_ff;
    wire         moved = sclk_q_ff != serial_clock_o;

    // cycles since the serial clock last moved
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_q_ff <= 1'b0;
            run_ff    <= 17'h00000;
        end else begin
            sclk_q_ff <= serial_clock_o;
            run_ff    <= moved ? 17'h00001 : run_ff + 17'h00001;
        end
    end

    sequence s_word_start;
        master_i ##0 $fell(chip_select_low_o);
    endsequence
    sequence s_idle_lead;
        serial_clock_o == clock_idle_polarity_i;
    endsequence

    chk_half_period: assert property (
        (moved && serial_clock_o == clock_idle_polarity_i && master_i
         && !ext_clock_i) |-> run_ff == {1'b0, serial_clock_divider_i} + 1)
        else $error("active clock phase length wrong");
    chk_clock_stopped: assert property (
        (!enable_i && $past(!enable_i)) |-> $stable(serial_clock_o))
        else $error("serial clock moved while disabled");
    chk_cs_idle_off: assert property (
        (!enable_i && !busy_o) |-> chip_select_low_o)
        else $error("select active while disabled");
    chk_start_enabled: assert property (
        $fell(chip_select_low_o) |-> $past(enable_i))
        else $error("word started while disabled");
    chk_lead_idle: assert property (
        s_word_start |-> s_idle_lead)
        else $error("clock not idle at word start");
    chk_idle_clock: assert property (
        (master_i && chip_select_low_o) |-> s_idle_lead)
        else $error("clock not idle between words");
    chk_irq_combine: assert property (
        irq_o == |(int_status_o & int_enable_i))
        else $error("interrupt not masked status");
    chk_status_sticky: assert property (
        |($past(int_status_o) & ~int_status_o) |-> $past(status_clear_i))
        else $error("status bit dropped without clear");
    chk_read_answer: assert property (
        data_rvalid_o |-> $past(data_rd_i))
        else $error("read data without read");
    chk_clock_select: assert property (
        serial_clock_oe_o == (master_i && enable_i && !ext_clock_i))
        else $error("clock drive enable wrong");
endmodule

bind spi_master_slave_core spi_core_chk i_chk (
    .clk_i, .rst_n_i, .enable_i, .master_i, .ext_clock_i,
    .clock_idle_polarity_i, .serial_clock_divider_i, .int_enable_i,
    .data_rd_i, .data_rvalid_o, .status_clear_i, .int_status_o, .irq_o,
    .busy_o, .serial_clock_o, .serial_clock_oe_o, .chip_select_low_o
);

// *** spi_peer_model.sv ***
// peer serial device: idle-low clock, samples rising, drives falling
// assumes the core is master and drives clock and select
`timescale 1ns/1ps
module spi_peer_model (
    // serial pins
    input  wire logic  sclk_i,
    input  wire logic  cs_low_i,
    input  wire logic  mosi_i,
    input  wire logic  lsb_i,
    output logic       miso_o,
    // captured words
    output logic [7:0] got_o,
    output logic [7:0] got_cnt_o
);
    logic [7:0] rx_v;
    logic [7:0] k;
    int         bit_n;

    function automatic logic [2:0] pos(input int n);
        return lsb_i ? n[2:0] : 3'(7 - n);
    endfunction
    function automatic logic reply_bit(input int n);
        logic [7:0] r;
        r = 8'hC3 + k;
        return r[pos(n)];
    endfunction

    initial begin
        miso_o = 1'b0;
        got_o = 8'h00;
        got_cnt_o = 8'h00;
        rx_v = 8'h00;
        k = 8'h00;
        bit_n = 0;
    end
    always @(negedge cs_low_i) begin
        bit_n = 0;
        miso_o = reply_bit(0);
    end
    always @(posedge sclk_i) begin
        if (!cs_low_i) begin
            rx_v[pos(bit_n)] = mosi_i;
            bit_n++;
            if (bit_n == 8) begin
                bit_n = 0;
                k++;
                got_o = rx_v;
                got_cnt_o++;
            end
        end
    end
    always @(negedge sclk_i) if (!cs_low_i) miso_o = reply_bit(bit_n);
    // released line shows the inverse level
    always @(posedge cs_low_i) miso_o = ~miso_o;
endmodule

// *** test_spi_master_slave_core.sv ***
// testbench: master transfers against the peer model
// assumes 40 MHz clock, idle-low clock mode, full duplex
`timescale 1ns/1ps
module test_spi_master_slave_core;
    logic       clk_i, rst_n_i, enable_i, ext_clock_i, lsb_first_i;
    logic       data_wr_i, data_rd_i, status_clear_i;
    logic [3:0] int_enable_i;
    logic [7:0] data_wdata_i;
    logic       data_wready_o, data_rvalid_o, irq_o, busy_o, miso;
    logic       tx_dma_req_o, rx_dma_req_o, serial_clock_o;
    logic       serial_clock_oe_o, serial_data_o, chip_select_low_o;
    logic [7:0] data_rdata_o, got, got_cnt, seen_cnt;
    logic [3:0] int_status_o;
    logic [15:0] lf;
    logic [15:0] serial_clock_divider_i;
    logic [2:0] tx_threshold_i, rx_threshold_i;
    logic       full_duplex_i, chip_select_low_i;
    logic [7:0] exp_tx[$];
    logic [7:0] exp_rx[$];
    int         errors, n_tests, cycles, n_rd, i;

    spi_master_slave_core i_dut (
        .clk_i, .rst_n_i, .enable_i, .master_i(1'b1),
        .full_duplex_i, .lsb_first_i, .sync_format_i(1'b0),
        .ext_clock_i, .clock_idle_polarity_i(1'b0),
        .clock_phase_select_i(1'b0), .serial_clock_divider_i,
        .tx_threshold_i, .rx_threshold_i, .int_enable_i,
        .data_wr_i, .data_wdata_i, .data_wready_o, .data_rd_i,
        .data_rvalid_o, .data_rdata_o, .status_clear_i, .int_status_o,
        .irq_o, .tx_dma_req_o, .rx_dma_req_o, .busy_o, .serial_clock_o,
        .serial_clock_oe_o, .serial_data_o, .serial_data_i(miso),
        .external_serial_clock_in_i(1'b0), .chip_select_low_i,
        .chip_select_low_o
    );
    spi_peer_model i_peer (
        .sclk_i(serial_clock_o), .cs_low_i(chip_select_low_o),
        .mosi_i(serial_data_o), .lsb_i(lsb_first_i), .miso_o(miso),
        .got_o(got), .got_cnt_o(got_cnt)
    );

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input string name, input logic [7:0] e,
                         input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic conclude;
        if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic write_word(input logic [7:0] w);
        int t;
        @(negedge clk_i);
        data_wr_i = 1'b1;
        data_wdata_i = w;
        for (t = 0; t < 50; t++) begin
            if (data_wready_o === 1'b1) break;
            @(negedge clk_i);
        end
        exp_tx.push_back(w);
        @(negedge clk_i);
        data_wr_i = 1'b0;
    endtask
    task automatic read_word(input bit full);
        @(negedge clk_i);
        data_rd_i = 1'b1;
        if (full) exp_rx.push_back(8'hC3 + n_rd[7:0]);
        if (full) n_rd++;
        @(negedge clk_i);
        data_rd_i = 1'b0;
    endtask
    task automatic wait_idle;
        int t;
        repeat (10) @(negedge clk_i);
        for (t = 0; t < 4000; t++) begin
            if (busy_o === 1'b0 && chip_select_low_o === 1'b1) break;
            @(negedge clk_i);
        end
        if (t == 4000) errors++;
    endtask

    // results: oldest note against what appears
    always @(posedge clk_i) begin
        if (got_cnt !== seen_cnt) begin
            seen_cnt = got_cnt;
            check("peer word", exp_tx.size() ? exp_tx.pop_front() : 8'hxx, got);
        end
        if (data_rvalid_o === 1'b1)
            check("read data", exp_rx.size() ? exp_rx.pop_front() : 8'hxx, data_rdata_o);
        cycles++;
        if (cycles == 20000) begin
            errors++;
            conclude();
        end
    end

    initial begin
        rst_n_i = 1'b0;
        enable_i = 1'b0;
        ext_clock_i = 1'b0;
        lsb_first_i = 1'b0;
        full_duplex_i = 1'b1;
        chip_select_low_i = 1'b1;
        serial_clock_divider_i = 16'h0007;
        tx_threshold_i = 3'h1;
        rx_threshold_i = 3'h1;
        int_enable_i = 4'h8;
        data_wr_i = 1'b0;
        data_rd_i = 1'b0;
        data_wdata_i = 8'h00;
        status_clear_i = 1'b0;
        seen_cnt = 8'h00;
        lf = 16'hCBA8;
        repeat (12) @(negedge clk_i);
        rst_n_i = 1'b1;
        check("idle clock", 8'h00, {7'h00, serial_clock_o});
        check("select", 8'h01, {7'h00, chip_select_low_o});
        check("status", 8'h00, {4'h0, int_status_o});
        for (i = 0; i < 3; i++) begin
            lf = lfsr(lf);
            write_word(lf[7:0]);
        end
        repeat (60) @(negedge clk_i);
        check("held clock", 8'h00, {7'h00, serial_clock_o});
        check("tx request", 8'h00, {7'h00, tx_dma_req_o});
        enable_i = 1'b1;
        wait_idle();
        check("rx request", 8'h01, {7'h00, rx_dma_req_o});
        check("tx request on", 8'h01, {7'h00, tx_dma_req_o});
        check("rx level", 8'h01, {7'h00, int_status_o[3]});
        check("irq on", 8'h01, {7'h00, irq_o});
        int_enable_i = 4'h0;
        @(negedge clk_i);
        check("irq masked", 8'h00, {7'h00, irq_o});
        for (i = 0; i < 3; i++) read_word(1'b1);
        read_word(1'b0);
        status_clear_i = 1'b1;
        @(negedge clk_i);
        status_clear_i = 1'b0;
        @(negedge clk_i);
        check("cleared", 8'h04, {4'h0, int_status_o});
        lsb_first_i = 1'b1;
        serial_clock_divider_i = 16'h0003;
        for (i = 0; i < 2; i++) begin
            lf = lfsr(lf);
            write_word(lf[7:0]);
        end
        wait_idle();
        for (i = 0; i < 2; i++) read_word(1'b1);
        enable_i = 1'b0;
        ext_clock_i = 1'b1;
        repeat (3) @(negedge clk_i);
        check("clock drive", 8'h00, {7'h00, serial_clock_oe_o});
        check("left over", 8'h00, 8'(exp_tx.size() + exp_rx.size()));
        conclude();
    end
endmodule
